// [hw/timer_pkg.sv]
// Purpose: Shared constants and types for the dual timer/counter
// Assumes: 8-bit special function register port, 50 MHz system clock
// Notes: Register offsets other than the mode register are local picks
package timer_pkg;

    // ========================================
    // Register offsets
    localparam logic [7:0] OFS_CONTROL = 8'h88;
    localparam logic [7:0] OFS_MODE = 8'h89;
    localparam logic [7:0] OFS_LOW0 = 8'h8a;
    localparam logic [7:0] OFS_LOW1 = 8'h8b;
    localparam logic [7:0] OFS_HIGH0 = 8'h8c;
    localparam logic [7:0] OFS_HIGH1 = 8'h8d;
    localparam logic [7:0] OFS_CLKDIV = 8'h8e;

    // ========================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ========================================
    // Control register bit positions
    localparam int BIT_OVF1 = 7;
    localparam int BIT_RUN1 = 6;
    localparam int BIT_OVF0 = 5;
    localparam int BIT_RUN0 = 4;

    // ========================================
    // Mode register bit positions
    localparam int BIT_GATE_CONTROL_1 = 7;
    localparam int BIT_SRC1 = 6;
    localparam int BIT_MODE1_HI = 5;
    localparam int BIT_MODE1_LO = 4;
    localparam int BIT_GATE_CONTROL_0 = 3;
    localparam int BIT_SRC0 = 2;
    localparam int BIT_MODE0_HI = 1;
    localparam int BIT_MODE0_LO = 0;

    // ========================================
    // Clock divider register bit positions
    localparam int BIT_TICK1 = 4;
    localparam int BIT_TICK0 = 3;

    // ========================================
    // Mode codes
    localparam logic [1:0] MODE_13 = 2'h0;
    localparam logic [1:0] MODE_16 = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // ========================================
    // Tick prescaler
    localparam int TICK_DIV = 12;
    localparam logic [3:0] PRESC_LAST = 4'(TICK_DIV - 1);
    localparam logic [3:0] PRESC_ZERO = 4'h0;
    localparam logic [3:0] PRESC_ONE = 4'h1;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic ovf;
    } count_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } sfr_req_t;

endpackage

// [hw/fall_detect.sv]
// Purpose: Falling-edge detector for an external event pin
// Assumes: Pin is synchronous to clk
// Notes: One-cycle pulse, one cycle after the low level is seen
`timescale 1ns/1ps
module fall_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic pin,
    output logic fall
);
    logic prev;
    logic next_prev;
    logic next_fall;

    always_comb begin
        next_prev = pin;
        next_fall = prev & ~pin;
    end

    // Idle level of the pin is high, so no edge right after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b1;
            fall <= 1'b0;
        end else if (ce) begin
            prev <= next_prev;
            fall <= next_fall;
        end
    end
endmodule

// [hw/dual_timer_counter.sv]
// Purpose: Two 16-bit timer/counters with four modes each
// Assumes: Register port is synchronous; pins synchronous to clk
// Notes: Read data is registered, one cycle behind the address
//
// Summary of operation
// [RULE1] Timer function advances once per tick: clock divided by one or twelve.
// [RULE2] Counter function advances on each falling edge of the event pin.
// [RULE3] Event source holds each level at least two clock cycles.
// [RULE4] 13-bit mode: high byte has top eight bits, low bits 4..0 rest.
// [RULE5] 13-bit rollover to zero sets the overflow flag.
// [RULE6] Source select 0 counts ticks, 1 counts event pin falling edges.
// [RULE7] Count only when run is set and gate off or gate input high.
// [RULE8] Setting run leaves the count unchanged.
// [RULE9] 16-bit mode counts over both bytes, configured like 13-bit.
// [RULE10] Auto-reload: low byte counts, reloads from high byte on rollover.
// [RULE11] Mode field 00 13-bit, 01 16-bit, 10 reload, 11 mode 3.
// [RULE12] Mode 3 splits timer 0 in two bytes; timer 1 stops.
// [RULE13] Timer 1 mirrors timer 0 with its own bits and inputs.
// [RULE14] Mode register holds gate, source, mode; resets zero; read/write.
// [RULE15] Mode 3 upper byte counts ticks under run 1, sets flag 1.
`timescale 1ns/1ps
module dual_timer_counter
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire timer_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic event_pin_0,
    input wire logic event_pin_1,
    input wire logic ext_gate_input_0,
    input wire logic ext_gate_input_1,
    output logic overflow_flag_0,
    output logic overflow_flag_1
);
    import timer_pkg::*;

    // ========================================
    // Step function shared by both timers
    function automatic count_t count_step(input logic [1:0] mode,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi,
                                          input logic inc);
        count_t r;
        logic [12:0] v13;
        logic [15:0] v16;
        r.lo = lo;
        r.hi = hi;
        r.ovf = 1'b0;
        v13 = {hi, lo[4:0]};
        v16 = {hi, lo};
        if (inc) begin
            case (mode)
                // [RULE4] [RULE5] 13-bit count
                MODE_13: begin
                    r.ovf = &v13;
                    v13 = v13 + 13'h0001;
                    r.hi = v13[12:5];
                    r.lo = {lo[7:5], v13[4:0]};
                end
                // [RULE9] full 16 bits
                MODE_16: begin
                    r.ovf = &v16;
                    v16 = v16 + 16'h0001;
                    r.hi = v16[15:8];
                    r.lo = v16[7:0];
                end
                // [RULE10] reload from high byte
                MODE_RELOAD: begin
                    r.ovf = &lo;
                    r.lo = (&lo) ? hi : lo + 8'h01;
                end
                default: begin
                    r.ovf = &lo;
                    r.lo = lo + 8'h01;
                end
            endcase
        end
        return r;
    endfunction

    // ========================================
    // Registers
    logic [7:0] low_count_byte_0;
    logic [7:0] high_count_byte_0;
    logic [7:0] low_count_byte_1;
    logic [7:0] high_count_byte_1;
    logic [7:0] timer_mode_reg;
    logic [7:0] clock_divider_reg;
    logic run_bit_0;
    logic run_bit_1;
    logic [3:0] presc;

    logic [7:0] next_low0;
    logic [7:0] next_high0;
    logic [7:0] next_low1;
    logic [7:0] next_high1;
    logic [7:0] next_mode;
    logic [7:0] next_clkdiv;
    logic next_run0;
    logic next_run1;
    logic next_ovf0;
    logic next_ovf1;
    logic [3:0] next_presc;
    logic [7:0] next_rdata;

    logic fall0;
    logic fall1;

    fall_detect edge0 (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(event_pin_0),
        .fall(fall0)
    );

    fall_detect edge1 (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(event_pin_1),
        .fall(fall1)
    );

    // ========================================
    // Count logic
    logic gate_control_0;
    logic gate_control_1;
    logic count_source_sel_0;
    logic count_source_sel_1;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic tick_divider_sel_0;
    logic tick_divider_sel_1;
    logic presc_wrap;
    logic tick0;
    logic tick1;
    logic en0;
    logic en1;
    logic inc0;
    logic inc1;
    logic inc_split_hi;
    logic wr;
    count_t step0;
    count_t step1;
    count_t step_hi;

    always_comb begin
        gate_control_0 = timer_mode_reg[BIT_GATE_CONTROL_0];
        gate_control_1 = timer_mode_reg[BIT_GATE_CONTROL_1];
        count_source_sel_0 = timer_mode_reg[BIT_SRC0];
        count_source_sel_1 = timer_mode_reg[BIT_SRC1];
        // [RULE11] mode field positions
        mode0 = timer_mode_reg[BIT_MODE0_HI:BIT_MODE0_LO];
        mode1 = timer_mode_reg[BIT_MODE1_HI:BIT_MODE1_LO];
        tick_divider_sel_0 = clock_divider_reg[BIT_TICK0];
        tick_divider_sel_1 = clock_divider_reg[BIT_TICK1];

        // [RULE1] divide by one or twelve
        presc_wrap = (presc == PRESC_LAST);
        next_presc = presc_wrap ? PRESC_ZERO : presc + PRESC_ONE;
        tick0 = tick_divider_sel_0 | presc_wrap;
        tick1 = tick_divider_sel_1 | presc_wrap;

        // [RULE7] [RULE13] run and gate qualification
        en0 = run_bit_0 & (~gate_control_0 | ext_gate_input_0);
        en1 = run_bit_1 & (~gate_control_1 | ext_gate_input_1);
        // [RULE6] [RULE2] source select
        inc0 = en0 & (count_source_sel_0 ? fall0 : tick0);
        // [RULE12] timer 1 halts in mode 3
        inc1 = en1 & (count_source_sel_1 ? fall1 : tick1)
             & (mode1 != MODE_SPLIT);
        // [RULE15] split upper byte runs from ticks under run 1
        inc_split_hi = run_bit_1 & tick0 & (mode0 == MODE_SPLIT);

        step0 = count_step(mode0, low_count_byte_0, high_count_byte_0, inc0);
        step_hi = count_step(MODE_SPLIT, high_count_byte_0, RST_BYTE,
                             inc_split_hi);
        step1 = count_step(mode1, low_count_byte_1, high_count_byte_1, inc1);

        next_low0 = step0.lo;
        next_high0 = (mode0 == MODE_SPLIT) ? step_hi.lo : step0.hi;
        next_low1 = step1.lo;
        next_high1 = step1.hi;
        next_mode = timer_mode_reg;
        next_clkdiv = clock_divider_reg;
        next_run0 = run_bit_0;
        next_run1 = run_bit_1;
        next_ovf0 = overflow_flag_0;
        next_ovf1 = overflow_flag_1;

        // Software writes to the count bytes win over counting in the same cycle
        wr = sfr_req.wr;
        if (wr) begin
            case (sfr_req.addr)
                OFS_LOW0: next_low0 = sfr_req.wdata;
                OFS_HIGH0: next_high0 = sfr_req.wdata;
                OFS_LOW1: next_low1 = sfr_req.wdata;
                OFS_HIGH1: next_high1 = sfr_req.wdata;
                // [RULE14] mode register write
                OFS_MODE: next_mode = sfr_req.wdata;
                OFS_CLKDIV: begin
                    next_clkdiv = RST_BYTE;
                    next_clkdiv[BIT_TICK0] = sfr_req.wdata[BIT_TICK0];
                    next_clkdiv[BIT_TICK1] = sfr_req.wdata[BIT_TICK1];
                end
                // [RULE8] run bits touch no count
                OFS_CONTROL: begin
                    next_run0 = sfr_req.wdata[BIT_RUN0];
                    next_run1 = sfr_req.wdata[BIT_RUN1];
                    next_ovf0 = sfr_req.wdata[BIT_OVF0];
                    next_ovf1 = sfr_req.wdata[BIT_OVF1];
                end
                default: ;
            endcase
        end

        // [RULE5] flags set by overflow; a set beats a clear
        if (step0.ovf) begin
            next_ovf0 = 1'b1;
        end
        // Timer 1 loses its flag to the split upper byte in mode 3
        if (mode0 == MODE_SPLIT) begin
            if (step_hi.ovf) begin
                next_ovf1 = 1'b1;
            end
        end else if (step1.ovf) begin
            next_ovf1 = 1'b1;
        end

        next_rdata = RST_BYTE;
        case (sfr_req.addr)
            OFS_LOW0: next_rdata = low_count_byte_0;
            OFS_HIGH0: next_rdata = high_count_byte_0;
            OFS_LOW1: next_rdata = low_count_byte_1;
            OFS_HIGH1: next_rdata = high_count_byte_1;
            OFS_MODE: next_rdata = timer_mode_reg;
            OFS_CLKDIV: next_rdata = clock_divider_reg;
            OFS_CONTROL: begin
                next_rdata[BIT_RUN0] = run_bit_0;
                next_rdata[BIT_RUN1] = run_bit_1;
                next_rdata[BIT_OVF0] = overflow_flag_0;
                next_rdata[BIT_OVF1] = overflow_flag_1;
            end
            default: next_rdata = RST_BYTE;
        endcase
    end

    // ========================================
    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_count_byte_0 <= RST_BYTE;
            high_count_byte_0 <= RST_BYTE;
            low_count_byte_1 <= RST_BYTE;
            high_count_byte_1 <= RST_BYTE;
            timer_mode_reg <= RST_BYTE;
            clock_divider_reg <= RST_BYTE;
            run_bit_0 <= 1'b0;
            run_bit_1 <= 1'b0;
            overflow_flag_0 <= 1'b0;
            overflow_flag_1 <= 1'b0;
            presc <= PRESC_ZERO;
            sfr_rdata <= RST_BYTE;
        end else if (ce) begin
            low_count_byte_0 <= next_low0;
            high_count_byte_0 <= next_high0;
            low_count_byte_1 <= next_low1;
            high_count_byte_1 <= next_high1;
            timer_mode_reg <= next_mode;
            clock_divider_reg <= next_clkdiv;
            run_bit_0 <= next_run0;
            run_bit_1 <= next_run1;
            overflow_flag_0 <= next_ovf0;
            overflow_flag_1 <= next_ovf1;
            presc <= next_presc;
            sfr_rdata <= next_rdata;
        end
    end
endmodule

// [sim/timer_chk.sv]
// Purpose: Port checks for the dual timer/counter
// Assumes: One clock, async active-low reset
// Notes: Count values are judged by the bench
`timescale 1ns/1ps
module timer_chk
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire timer_pkg::sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic overflow_flag_0,
    input wire logic overflow_flag_1
);
    import timer_pkg::*;
    // ====
    // Register port and flags
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic ctl_wr, clr0, clr1;
    assign ctl_wr = ce && sfr_req.wr && sfr_req.addr == OFS_CONTROL;
    assign clr0 = ctl_wr && !sfr_req.wdata[BIT_OVF0];
    assign clr1 = ctl_wr && !sfr_req.wdata[BIT_OVF1];
    a_reset_zero: assert property (
        $rose(rst_n) |-> sfr_rdata == RST_BYTE)
        else $error("read data not clear after reset");
    a_mode_readback: assert property (
        ce && sfr_req.wr && sfr_req.addr == OFS_MODE
        ##1 ce && !sfr_req.wr && sfr_req.addr == OFS_MODE
        |=> sfr_rdata == $past(sfr_req.wdata, 2))
        else $error("mode register lost its value");
    a_flag0_sw_set: assert property (
        ctl_wr && sfr_req.wdata[BIT_OVF0] |=> overflow_flag_0)
        else $error("flag 0 not set by write");
    a_flag0_fall: assert property (
        $fell(overflow_flag_0) |-> $past(clr0))
        else $error("flag 0 dropped without a clear");
    a_flag1_fall: assert property (
        $fell(overflow_flag_1) |-> $past(clr1))
        else $error("flag 1 dropped without a clear");
    a_unmapped_zero: assert property (
        ce && (sfr_req.addr < OFS_CONTROL || sfr_req.addr > OFS_CLKDIV)
        |=> sfr_rdata == RST_BYTE)
        else $error("unmapped read not zero");
    a_ctrl_low_zero: assert property (
        ce && sfr_req.addr == OFS_CONTROL |=> sfr_rdata[3:0] == 4'h0)
        else $error("control low bits not zero");
    a_divider_bits: assert property (
        ce && sfr_req.addr == OFS_CLKDIV |=> (sfr_rdata & 8'he7) == 8'h00)
        else $error("divider register spare bits set");
endmodule
bind dual_timer_counter timer_chk u_chk (.clk, .rst_n, .ce, .sfr_req,
    .sfr_rdata, .overflow_flag_0, .overflow_flag_1);

// [sim/event_partner.sv]
// Purpose: External event and gate pin source for the timer bench
// Assumes: Pins change just after a rising edge
// Notes: Pins idle high, as pulled-up port inputs do
`timescale 1ns/1ps
module event_partner (
    input wire logic clk,
    output logic event_pin_0,
    output logic event_pin_1,
    output logic ext_gate_input_0,
    output logic ext_gate_input_1
);
    // ====
    // Pin drivers
    initial begin
        event_pin_0 = 1'b1;
        event_pin_1 = 1'b1;
        ext_gate_input_0 = 1'b1;
        ext_gate_input_1 = 1'b1;
    end
    // level hold
    // Hold of two is the fastest legal rate
    task automatic send(input logic which, input int n, input int hold);
        repeat (n) begin
            for (int lvl = 0; lvl < 2; lvl++) begin
                @(posedge clk) #1;
                if (which) event_pin_1 = lvl[0];
                else event_pin_0 = lvl[0];
                repeat (hold - 1) @(posedge clk);
            end
        end
    endtask
    task automatic set_gate(input logic which, input logic lvl);
        @(posedge clk) #1;
        if (which) ext_gate_input_1 = lvl;
        else ext_gate_input_0 = lvl;
    endtask
endmodule

// [sim/dual_timer_counter_tb_top.sv]
// Purpose: Self-checking bench for the dual timer/counter
// Assumes: One-clock ticks keep each mode run to two counts
// Notes: Overflows land on the stopping write and must survive it
`timescale 1ns/1ps
`define CHECK(g, e) begin n_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); \
    end end
module dual_timer_counter_tb_top;
    import timer_pkg::*;
    // ====
    // Bench plumbing
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic event_pin_0, event_pin_1, ext_gate_input_0, ext_gate_input_1;
    logic overflow_flag_0, overflow_flag_1;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    dual_timer_counter u_dut (.clk, .rst_n, .ce, .sfr_req, .sfr_rdata,
        .event_pin_0, .event_pin_1, .ext_gate_input_0, .ext_gate_input_1,
        .overflow_flag_0, .overflow_flag_1);
    event_partner u_partner (.clk, .event_pin_0, .event_pin_1,
        .ext_gate_input_0, .ext_gate_input_1);
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ====
    // Register access helpers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        sfr_req = '{addr: a, wr: 1'b1, wdata: d};
        @(posedge clk) #1;
        sfr_req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) #1;
        sfr_req.addr = a;
        @(posedge clk) #1;
        `CHECK(sfr_rdata, e)
    endtask
    // Run stays on for exactly two counting edges
    task automatic run2(input logic [7:0] ctrl);
        wr(OFS_CONTROL, ctrl);
        wr(OFS_CONTROL, 8'h00);
    endtask
    task automatic load(input logic [31:0] b);
        wr(OFS_LOW0, b[31:24]);
        wr(OFS_HIGH0, b[23:16]);
        wr(OFS_LOW1, b[15:8]);
        wr(OFS_HIGH1, b[7:0]);
    endtask
    task automatic mode_run(input logic [7:0] m, input logic [31:0] pre,
        input logic [31:0] post, input logic [1:0] fl);
        wr(OFS_MODE, m);
        wr(OFS_CLKDIV, 8'h18);
        load(pre);
        run2(8'h50);
        `CHECK({overflow_flag_1, overflow_flag_0}, fl)
        rd(OFS_LOW0, post[31:24]);
        rd(OFS_HIGH0, post[23:16]);
        rd(OFS_LOW1, post[15:8]);
        rd(OFS_HIGH1, post[7:0]);
    endtask
    // ====
    // Scenarios
    task automatic t_regs();
        rd(8'h90, 8'h00);
        rd(OFS_MODE, 8'h00);
        wr(OFS_MODE, 8'ha5);
        rd(OFS_MODE, 8'ha5);
        wr(OFS_CONTROL, 8'ha0);
        `CHECK({overflow_flag_1, overflow_flag_0}, 2'b11)
        rd(OFS_CONTROL, 8'ha0);
    endtask
    task automatic t_modes();
        mode_run(8'h00, 32'h1eff1eff, 32'h0, 2'b11);
        mode_run(8'h11, 32'hfefffdff, 32'h0000ffff, 2'b01);
        mode_run(8'h22, 32'hfe40fd77, 32'h4040ff77, 2'b01);
        mode_run(8'h33, 32'hfefe1234, 32'h00001234, 2'b11);
        mode_run(8'ha2, 32'h1020fe33, 32'h12203333, 2'b10);
    endtask
    task automatic t_prescale();
        wr(OFS_MODE, 8'h01);
        wr(OFS_CLKDIV, 8'h00);
        load(32'h0);
        wr(OFS_CONTROL, 8'h10);
        repeat (118) @(posedge clk);
        wr(OFS_CONTROL, 8'h00);
        rd(OFS_LOW0, 8'h0a);
    endtask
    task automatic t_gate();
        wr(OFS_MODE, 8'h09);
        wr(OFS_CLKDIV, 8'h08);
        load(32'h55000000);
        u_partner.set_gate(1'b0, 1'b0);
        run2(8'h10);
        rd(OFS_LOW0, 8'h55);
        u_partner.set_gate(1'b0, 1'b1);
        run2(8'h10);
        rd(OFS_LOW0, 8'h57);
        u_partner.set_gate(1'b0, 1'b0);
        wr(OFS_MODE, 8'h01);
        run2(8'h10);
        rd(OFS_LOW0, 8'h59);
    endtask
    task automatic t_events();
        wr(OFS_MODE, 8'h55);
        load(32'h0);
        wr(OFS_CONTROL, 8'h50);
        fork
            u_partner.send(1'b0, 5, 2);
            u_partner.send(1'b1, 3, 3);
        join
        wr(OFS_CONTROL, 8'h00);
        rd(OFS_LOW0, 8'h05);
        rd(OFS_LOW1, 8'h03);
    endtask
    // Clock enable low for twenty edges; only the two live edges count
    task automatic t_freeze();
        wr(OFS_MODE, 8'h01);
        wr(OFS_CLKDIV, 8'h08);
        load(32'h0);
        wr(OFS_CONTROL, 8'h10);
        ce = 1'b0;
        repeat (20) @(posedge clk);
        #1 ce = 1'b1;
        wr(OFS_CONTROL, 8'h00);
        rd(OFS_LOW0, 8'h02);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        t_regs();
        t_modes();
        t_prescale();
        t_gate();
        t_events();
        t_freeze();
        give_verdict();
    end
endmodule
